//--- led_matrix_defines.svh
// Constants of the LED matrix command controller
`ifndef LED_MATRIX_DEFINES_SVH
`define LED_MATRIX_DEFINES_SVH

// ----------------------------------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------------------------------
`define REG_CTRL     8'h00
`define REG_STATUS   8'h04
`define REG_BYTES    8'h08
`define CTRL_BLANK   0
`define CTRL_RESET   1'h0

// ----------------------------------------------------------------
// Command decode
// ----------------------------------------------------------------
`define CMD_NONE     2'h0
`define CMD_DATA_SET 2'h1
`define CMD_DISP_CTL 2'h2
`define CMD_ADDR_SET 2'h3
`define DS_FIXED     2
`define DS_TEST      3
`define DC_ON        3
`define PTR_RESET    4'h0
`define CFG_RESET    6'h00

// ----------------------------------------------------------------
// Pulse widths in sixteenths of a cathode slot
// ----------------------------------------------------------------
`define PW_0 4'h1
`define PW_1 4'h2
`define PW_2 4'h4
`define PW_3 4'ha
`define PW_4 4'hb
`define PW_5 4'hc
`define PW_6 4'hd
`define PW_7 4'he

// ----------------------------------------------------------------
// Scan timing
// ----------------------------------------------------------------
`define CLK_NS     40
`define SUB_NS     2000
`define SUB_CYC    ((`SUB_NS + `CLK_NS - 1) / `CLK_NS)
`define SUB_CNT_W  6
`define SUB_LAST   4'hf
`define SLOT_LAST  3'h7

`endif

//--- led_matrix_pkg.sv
// Types shared by the LED matrix command controller
package led_matrix_pkg;

  typedef struct packed {
    logic       test_mode;
    logic       fixed_addr;
    logic       disp_on;
    logic [2:0] width;
  } cfg_t;

  typedef struct packed {
    logic [7:0] data;
    logic       toggle;
  } link_byte_t;

  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_CMD  = 4'b0010,
    ST_DATA = 4'b0100,
    ST_SKIP = 4'b1000
  } frame_st_t;

endpackage

//--- display_mem.sv
// Display memory, 16 bytes, read out as cathode byte pairs
`timescale 1ns/1ps
module display_mem (
  input  wire logic        clk_i,
  input  wire logic        ce_i,
  input  wire logic        we_i,
  input  wire logic [3:0]  waddr_i,
  input  wire logic [7:0]  wdata_i,
  input  wire logic [2:0]  raddr_i,
  output logic      [15:0] rdata_o
);
  // No reset: contents are random until written
  logic [7:0] mem [16];

  always_ff @(posedge clk_i) begin
    if (ce_i) begin
      if (we_i) begin
        mem[waddr_i] <= wdata_i;
      end
      rdata_o <= {mem[{raddr_i, 1'b1}], mem[{raddr_i, 1'b0}]};
    end
  end
endmodule // display_mem

//--- serial_rx.sv
// Serial byte assembler on the link clock
`timescale 1ns/1ps
module serial_rx (
  input  wire logic                        sclk_i,
  input  wire logic                        frame_n_i,
  input  wire logic                        sdin_i,
  input  wire logic                        rst_i,
  output led_matrix_pkg::link_byte_t       link_o
);
  import led_matrix_pkg::*;

  logic       [6:0] shift;
  logic       [2:0] cnt;
  logic       [6:0] next_shift;
  logic       [2:0] next_cnt;
  link_byte_t       next_link;
  logic             clr;

  // Frame select high clears a partial byte
  assign clr = rst_i | frame_n_i; // R12

  always_comb begin
    next_shift = {sdin_i, shift[6:1]}; // R07
    next_cnt   = cnt + 3'h1;
    next_link  = link_o;
    if (cnt == 3'h7) begin
      next_link.data   = {sdin_i, shift}; // R07
      next_link.toggle = ~link_o.toggle;
    end
  end

  always_ff @(posedge sclk_i or posedge clr) begin // R13
    if (clr) begin
      shift <= 7'h00;
      cnt   <= 3'h0;
    end else begin
      shift <= next_shift;
      cnt   <= next_cnt;
    end
  end

  // Held byte and toggle survive the frame end
  always_ff @(posedge sclk_i or posedge rst_i) begin
    if (rst_i) begin
      link_o <= '0;
    end else if (!frame_n_i) begin
      link_o <= next_link;
    end
  end
endmodule // serial_rx

//--- led_matrix_serial_cmd_ctrl.sv
// Serial command decoder, display memory writer and LED scanner
`timescale 1ns/1ps
`include "led_matrix_defines.svh"

// Rules this block and its host follow
// R01 - Address command selects one of sixteen bytes
// R02 - Write pointer starts at first location
// R03 - Control command low bits choose pulse width
// R04 - Display switch bit blanks or drives outputs
// R05 - Host sends at most sixteen auto bytes
// R06 - Auto mode stores bytes at rising addresses
// R07 - Bytes travel least significant bit first
// R08 - Fixed mode: one byte per frame
// R09 - Fixed mode: fresh address each further byte
// R10 - Host switches display on afterwards
// R11 - First byte of frame is command
// R12 - Frame end discards a partial byte
// R13 - Data sampled on serial clock rising edge
// R14 - Mode bits pick fixed and test, reset zero
// R15 - Cathodes scanned in turn from internal clock
// R16 - Auto increment wraps after last location
module led_matrix_serial_cmd_ctrl (
  input  wire logic        CLK_SYS_I,
  input  wire logic        RST_I,
  input  wire logic        CE_I,
  input  wire logic        SERIAL_CLK_I,
  input  wire logic        FRAME_SELECT_N_I,
  input  wire logic        SERIAL_DATA_I,
  input  wire logic        PSEL_I,
  input  wire logic        PENABLE_I,
  input  wire logic        PWRITE_I,
  input  wire logic [7:0]  PADDR_I,
  input  wire logic [31:0] PWDATA_I,
  output logic      [31:0] PRDATA_O,
  output logic             PREADY_O,
  output logic             PSLVERR_O,
  output logic      [15:0] ANODE_DRIVE_O,
  output logic      [7:0]  CATHODE_SCAN_O,
  output logic      [7:0]  CATHODE_SCAN_OE_N_O
);
  import led_matrix_pkg::*;

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  link_byte_t                  link;
  logic                        frame_meta;
  logic                        frame_s;
  logic                        tog_meta;
  logic                        tog_s;
  logic                        tog_d;
  logic                        take;
  logic       [7:0]            rx_byte;
  logic       [1:0]            cmd;

  frame_st_t                   state;
  frame_st_t                   next_state;
  cfg_t                        cfg;
  cfg_t                        next_cfg;
  logic       [3:0]            wptr;
  logic       [3:0]            next_wptr;
  logic                        mem_we;
  logic       [15:0]           byte_cnt;
  logic       [15:0]           next_byte_cnt;

  logic                        blank;
  logic                        next_blank;
  logic       [31:0]           next_prdata;
  logic                        next_pready;
  logic                        next_pslverr;
  logic                        setup;
  logic                        access;
  logic                        mapped;

  logic       [`SUB_CNT_W-1:0] cyc;
  logic       [`SUB_CNT_W-1:0] next_cyc;
  logic       [3:0]            sub;
  logic       [3:0]            next_sub;
  logic       [2:0]            slot;
  logic       [2:0]            next_slot;
  logic       [15:0]           rdata;
  logic                        lit;
  logic       [15:0]           next_anode;
  logic       [7:0]            next_oe_n;

  // Width code to lit sixteenths of a slot
  function automatic logic [3:0] pulse_len(input logic [2:0] code);
    logic [3:0] len;
    len = `PW_0;
    unique case (code) // R03
      3'h0: len = `PW_0;
      3'h1: len = `PW_1;
      3'h2: len = `PW_2;
      3'h3: len = `PW_3;
      3'h4: len = `PW_4;
      3'h5: len = `PW_5;
      3'h6: len = `PW_6;
      3'h7: len = `PW_7;
    endcase
    return len;
  endfunction

  // ----------------------------------------------------------------
  // Link side and crossing
  // ----------------------------------------------------------------
  serial_rx u_rx (
    .sclk_i    (SERIAL_CLK_I),
    .frame_n_i (FRAME_SELECT_N_I),
    .sdin_i    (SERIAL_DATA_I),
    .rst_i     (RST_I),
    .link_o    (link)
  );

  always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
    if (RST_I) begin
      frame_meta <= 1'b1;
      frame_s    <= 1'b1;
      tog_meta   <= 1'b0;
      tog_s      <= 1'b0;
      tog_d      <= 1'b0;
    end else if (CE_I) begin
      frame_meta <= FRAME_SELECT_N_I;
      frame_s    <= frame_meta;
      tog_meta   <= link.toggle;
      tog_s      <= tog_meta;
      tog_d      <= tog_s;
    end
  end

  // Byte held stable on the link side until the next toggle
  assign take    = CE_I & (tog_s ^ tog_d);
  assign rx_byte = link.data;
  assign cmd     = rx_byte[7:6];

  // ----------------------------------------------------------------
  // Command decoder
  // ----------------------------------------------------------------
  always_comb begin
    next_state    = state;
    next_cfg      = cfg;
    next_wptr     = wptr;
    mem_we        = 1'b0;
    next_byte_cnt = take ? byte_cnt + 16'h0001 : byte_cnt;
    unique case (state)
      ST_IDLE: begin
        if (!frame_s) begin
          next_state = ST_CMD;
        end
      end
      ST_CMD: begin
        if (take) begin // R11
          next_state = ST_SKIP;
          unique case (cmd)
            `CMD_ADDR_SET: begin
              next_wptr  = rx_byte[3:0]; // R01
              next_state = ST_DATA;
            end
            `CMD_DATA_SET: begin
              next_cfg.fixed_addr = rx_byte[`DS_FIXED]; // R14
              next_cfg.test_mode  = rx_byte[`DS_TEST]; // R14
            end
            `CMD_DISP_CTL: begin
              next_cfg.disp_on = rx_byte[`DC_ON]; // R04
              next_cfg.width   = rx_byte[2:0]; // R03
            end
            `CMD_NONE: begin
              next_state = ST_SKIP;
            end
          endcase
        end
      end
      ST_DATA: begin
        if (take) begin
          mem_we = 1'b1;
          // Pointer wraps from the last location to the first
          if (!cfg.fixed_addr) begin
            next_wptr = wptr + 4'h1; // R06 R16
          end
        end
      end
      ST_SKIP: begin
        next_state = ST_SKIP;
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
    if (frame_s) begin
      next_state = ST_IDLE; // R12
    end
  end

  always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
    if (RST_I) begin
      state    <= ST_IDLE;
      cfg      <= `CFG_RESET;
      wptr     <= `PTR_RESET; // R02
      byte_cnt <= 16'h0000;
    end else if (CE_I) begin
      state    <= next_state;
      cfg      <= next_cfg;
      wptr     <= next_wptr;
      byte_cnt <= next_byte_cnt;
    end
  end

  display_mem u_mem (
    .clk_i   (CLK_SYS_I),
    .ce_i    (CE_I),
    .we_i    (mem_we),
    .waddr_i (wptr),
    .wdata_i (rx_byte),
    .raddr_i (next_slot),
    .rdata_o (rdata)
  );

  // ----------------------------------------------------------------
  // APB slave, zero wait states
  // ----------------------------------------------------------------
  assign setup  = PSEL_I & ~PENABLE_I;
  assign access = PSEL_I & PENABLE_I & PREADY_O;
  assign mapped = (PADDR_I == `REG_CTRL) | (PADDR_I == `REG_STATUS)
                | (PADDR_I == `REG_BYTES);

  always_comb begin
    next_pready  = setup;
    next_pslverr = setup & ~mapped;
    next_prdata  = PRDATA_O;
    next_blank   = blank;
    if (setup) begin
      next_prdata = 32'h0000_0000;
      if (PADDR_I == `REG_CTRL) begin
        next_prdata = {31'h0000_0000, blank};
      end else if (PADDR_I == `REG_STATUS) begin
        next_prdata = {12'h000, state, 4'h0, wptr, 2'h0, cfg};
      end else if (PADDR_I == `REG_BYTES) begin
        next_prdata = {16'h0000, byte_cnt};
      end
    end
    if (access && PWRITE_I && PADDR_I == `REG_CTRL) begin
      next_blank = PWDATA_I[`CTRL_BLANK];
    end
  end

  always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
    if (RST_I) begin
      PRDATA_O  <= 32'h0000_0000;
      PREADY_O  <= 1'b0;
      PSLVERR_O <= 1'b0;
      blank     <= `CTRL_RESET;
    end else if (CE_I) begin
      PRDATA_O  <= next_prdata;
      PREADY_O  <= next_pready;
      PSLVERR_O <= next_pslverr;
      blank     <= next_blank;
    end
  end

  // ----------------------------------------------------------------
  // Cathode scan and pulse width
  // ----------------------------------------------------------------
  always_comb begin
    next_cyc  = cyc + `SUB_CNT_W'(1);
    next_sub  = sub;
    next_slot = slot;
    if (cyc == `SUB_CNT_W'(`SUB_CYC - 1)) begin
      next_cyc = '0;
      next_sub = sub + 4'h1;
      if (sub == `SUB_LAST) begin
        next_slot = slot + 3'h1; // R15
      end
    end
    lit        = cfg.disp_on & ~blank & (sub < pulse_len(cfg.width)); // R03 R04
    next_anode = lit ? rdata : 16'h0000; // R15
    next_oe_n  = lit ? ~(8'h01 << slot) : 8'hff;
  end

  always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
    if (RST_I) begin
      cyc                 <= '0;
      sub                 <= 4'h0;
      slot                <= 3'h0;
      ANODE_DRIVE_O       <= 16'h0000;
      CATHODE_SCAN_O      <= 8'h00;
      CATHODE_SCAN_OE_N_O <= 8'hff;
    end else if (CE_I) begin
      cyc                 <= next_cyc;
      sub                 <= next_sub;
      slot                <= next_slot;
      ANODE_DRIVE_O       <= next_anode;
      CATHODE_SCAN_O      <= 8'h00;
      CATHODE_SCAN_OE_N_O <= next_oe_n;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge CLK_SYS_I); endclocking
  default disable iff (RST_I);

  addr_cmd_a: assert property ( // R01
    take && state == ST_CMD && cmd == `CMD_ADDR_SET
    |=> wptr == $past(rx_byte[3:0]) && state == ST_DATA)
    else $error("address command not applied");

  ptr_hold_a: assert property ( // R02
    CE_I && !(take && (state == ST_CMD || state == ST_DATA))
    |=> $stable(wptr))
    else $error("write pointer moved without cause");

  width_set_a: assert property ( // R03
    take && state == ST_CMD && cmd == `CMD_DISP_CTL
    |=> cfg.width == $past(rx_byte[2:0]) && cfg.disp_on == $past(rx_byte[3]))
    else $error("display control not applied");

  pulse_len_a: assert property ( // R03
    $past(CE_I) && ANODE_DRIVE_O != 16'h0000 |-> $past(sub) < pulse_len($past(cfg.width)))
    else $error("anodes lit past pulse width");

  blank_off_a: assert property ( // R04
    CE_I && !cfg.disp_on |=> ANODE_DRIVE_O == 16'h0000 && CATHODE_SCAN_OE_N_O == 8'hff)
    else $error("outputs driven while display off");

  auto_inc_a: assert property ( // R06
    take && state == ST_DATA && !cfg.fixed_addr
    |=> wptr == $past(wptr) + 4'h1)
    else $error("auto increment failed");

  mode_set_a: assert property ( // R14
    take && state == ST_CMD && cmd == `CMD_DATA_SET
    |=> cfg.fixed_addr == $past(rx_byte[2]) && cfg.test_mode == $past(rx_byte[3]))
    else $error("data write setting not applied");

  frame_end_a: assert property ( // R12
    CE_I && frame_s |=> state == ST_IDLE)
    else $error("frame end did not return to idle");

  slot_step_a: assert property ( // R15
    CE_I && cyc == `SUB_CNT_W'(`SUB_CYC - 1) && sub == `SUB_LAST
    |=> slot == $past(slot) + 3'h1)
    else $error("cathode slot did not advance");

endmodule // led_matrix_serial_cmd_ctrl

//--- serial_host.sv
// Host model that drives the three-wire serial command link
`timescale 1ns/1ps
module serial_host (
  output logic sclk_o,
  output logic frame_n_o,
  output logic sdata_o
);
  // ------------------------------------------------------------
  // Idle link: clock parked high, frame released
  // ------------------------------------------------------------
  initial begin
    sclk_o    = 1'h1;
    frame_n_o = 1'h1;
    sdata_o   = 1'h0;
  end

  // ------------------------------------------------------------
  // One frame; the last byte may be cut short to last_bits
  // ------------------------------------------------------------
  task automatic frame(input logic [7:0] q[$], input int last_bits);
    frame_n_o = 1'h0;
    #203;
    foreach (q[i]) begin
      for (int b = 0; b < ((i == q.size() - 1) ? last_bits : 8); b++) begin
        sclk_o  = 1'h0;
        sdata_o = q[i][b];
        #16;
        sclk_o = 1'h1;
        #16;
      end
    end
    #200;
    // Released data line must not keep the last bit
    sdata_o   = ~sdata_o;
    frame_n_o = 1'h1;
    #200;
  endtask
endmodule  // serial_host

//--- tb.sv
// Self-checking bench for the LED matrix command controller
`timescale 1ns/1ps
module tb;
  // ------------------------------------------------------------
  // Signals
  // ------------------------------------------------------------
  logic        clk, rst, ce, psel, penable, pwrite, err, pready, pslverr;
  logic        sclk, frame_n, sdata;
  logic [7:0]  paddr, oe_n, cath;
  logic [31:0] pwdata, prdata, rd;
  logic [15:0] anode;
  logic [7:0]  mem [16];
  logic [7:0]  q [$];
  int          n_fail = 0, checked = 0, cycles = 0, nbytes = 0, lit, len;
  int          pw [8] = '{1, 2, 4, 10, 11, 12, 13, 14};

  led_matrix_serial_cmd_ctrl dut (
    .CLK_SYS_I(clk), .RST_I(rst), .CE_I(ce), .SERIAL_CLK_I(sclk),
    .FRAME_SELECT_N_I(frame_n), .SERIAL_DATA_I(sdata), .PSEL_I(psel),
    .PENABLE_I(penable), .PWRITE_I(pwrite), .PADDR_I(paddr), .PWDATA_I(pwdata),
    .PRDATA_O(prdata), .PREADY_O(pready), .PSLVERR_O(pslverr),
    .ANODE_DRIVE_O(anode), .CATHODE_SCAN_O(cath), .CATHODE_SCAN_OE_N_O(oe_n));

  serial_host host (.sclk_o(sclk), .frame_n_o(frame_n), .sdata_o(sdata));

  initial begin
    clk = 1'h0;
    forever #20 clk = ~clk;
  end

  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 60000) begin
      n_fail = n_fail + 1;
      print_verdict();
    end
  end

  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  task automatic print_verdict();
    $display("checked %0d n_fail %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic cmp(input string nm, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask

  function automatic logic [31:0] st(input int w, on, fx, ts, p);
    return {12'h0, 4'h1, 4'h0, p[3:0], 2'h0, ts[0], fx[0], on[0], w[2:0]};
  endfunction

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    @(posedge clk);
    psel    <= 1'h1;
    penable <= 1'h0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= wd;
    @(posedge clk);
    penable <= 1'h1;
    // No wait count assumed; the bench timeout ends a hang
    do begin
      @(posedge clk);
    end while (pready !== 1'h1);
    rd      = prdata;
    err     = pslverr;
    psel    <= 1'h0;
    penable <= 1'h0;
  endtask

  task automatic chk_rd(input logic [7:0] a, input logic [31:0] exp, input string nm);
    apb(1'h0, a, 32'h0);
    cmp(nm, exp, rd);
  endtask

  task automatic send(input int bits);
    host.frame(q, bits);
    nbytes += (bits == 8) ? q.size() : q.size() - 1;
    repeat (10) @(posedge clk);
  endtask

  // Lit cycles and length of the next whole cathode slot
  task automatic lit_slot();
    int t;
    lit = 0;
    len = 0;
    for (t = 0; t < 1000 && oe_n !== 8'hff; t++) @(posedge clk);
    for (t = 0; t < 1000 && oe_n === 8'hff; t++) @(posedge clk);
    // Slot runs from one lit start to the next
    while (len < 1000 && oe_n !== 8'hff) begin
      if (anode !== 16'h0) lit++;
      len++;
      @(posedge clk);
    end
    while (len < 1000 && oe_n === 8'hff) begin
      if (anode !== 16'h0) lit++;
      len++;
      @(posedge clk);
    end
  endtask

  task automatic scan();
    int t;
    for (int k = 0; k < 8; k++) begin
      for (t = 0; t < 7000 && oe_n !== ~(8'h01 << k); t++) @(posedge clk);
      repeat (3) @(posedge clk);
      cmp("anode", {16'h0, mem[2*k+1], mem[2*k]}, {16'h0, anode});
      cmp("cathode", 32'h0, {24'h0, cath});
    end
  endtask

  // Clock enable low must hold the anode and cathode enable outputs for a whole slot
  task automatic freeze();
    logic [31:0] s;
    ce <= 1'h0;
    @(posedge clk);
    s = {8'h0, oe_n, anode};
    repeat (800) @(posedge clk);
    cmp("freeze", s, {8'h0, oe_n, anode});
    ce <= 1'h1;
  endtask

  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    rst = 1'h1;
    ce = 1'h1;
    psel = 1'h0;
    penable = 1'h0;
    pwrite = 1'h0;
    paddr = 8'h0;
    pwdata = 32'h0;
    repeat (10) @(posedge clk);
    rst <= 1'h0;
    repeat (4) @(posedge clk);
    chk_rd(8'h04, st(0, 0, 0, 0, 0), "status");
    chk_rd(8'h00, 32'h0, "ctrl");
    apb(1'h1, 8'h00, 32'hffffffff);
    chk_rd(8'h00, 32'h1, "ctrl rw");
    apb(1'h1, 8'h04, 32'hffffffff);
    chk_rd(8'h04, st(0, 0, 0, 0, 0), "status ro");
    apb(1'h0, 8'h0c, 32'h0);
    cmp("slverr", 32'h1, {31'h0, err});
    cmp("slverr data", 32'h0, rd);
    apb(1'h1, 8'h00, 32'h0);
    // Auto-increment fill and wrap
    for (int i = 0; i < 16; i++) mem[i] = {i[3:0], ~i[3:0]};
    q = {8'h40};
    send(8);
    q = {8'hc0};
    foreach (mem[i]) q.push_back(mem[i]);
    send(8);
    chk_rd(8'h04, st(0, 0, 0, 0, 0), "ptr wrap");
    q = {8'hce, 8'h5a, 8'h96, 8'h0f};
    send(8);
    mem[14] = 8'h5a;
    mem[15] = 8'h96;
    mem[0] = 8'h0f;
    chk_rd(8'h04, st(0, 0, 0, 0, 1), "ptr");
    // Every pulse width
    for (int w = 0; w < 8; w++) begin
      q = {8'h88 | 8'(w)};
      send(8);
      chk_rd(8'h04, st(w, 1, 0, 0, 1), "width");
      lit_slot();
      cmp("lit", 32'(pw[w] * 50), 32'(lit));
      cmp("slot", 32'd800, 32'(len));
    end
    scan();
    freeze();
    q = {8'h80};
    send(8);
    lit_slot();
    cmp("dark", 32'h0, 32'(lit));
    q = {8'h8f};
    send(8);
    apb(1'h1, 8'h00, 32'h1);
    lit_slot();
    cmp("blank", 32'h0, 32'(lit));
    apb(1'h1, 8'h00, 32'h0);
    // Fixed address mode
    q = {8'h44};
    send(8);
    q = {8'hc5, 8'h3c};
    send(8);
    q = {8'hca, 8'hc3};
    send(8);
    mem[5] = 8'h3c;
    mem[10] = 8'hc3;
    chk_rd(8'h04, st(7, 1, 1, 0, 10), "fixed ptr");
    // Partial bytes dropped at frame end
    q = {8'hc2, 8'h55};
    send(4);
    q = {8'h48};
    send(8);
    chk_rd(8'h04, st(7, 1, 0, 1, 2), "test");
    q = {8'h80};
    send(5);
    chk_rd(8'h04, st(7, 1, 0, 1, 2), "partial cmd");
    q = {8'h0f, 8'h77};
    send(8);
    chk_rd(8'h04, st(7, 1, 0, 1, 2), "cmd none");
    scan();
    chk_rd(8'h08, 32'(nbytes), "bytes");
    print_verdict();
  end
endmodule  // tb
